//--- logic/i2c_ctl_defs.vh
// Register map, field positions and reset values of the channel control block
`ifndef I2C_CTL_DEFS_VH
`define I2C_CTL_DEFS_VH

// ----------------------------------------------------------------
// Channel count and register offsets
// ----------------------------------------------------------------
`define CH_NUM          3
`define OFS_CH0_CTRL    8'hc0
`define OFS_CH1_CTRL    8'hd0
`define OFS_CH2_CTRL    8'he0
`define OFS_CHAN_ON     8'hf0
`define OFS_STUCK       8'hf4

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define BIT_HALT_SEQ    7
`define BIT_BEGIN       6
`define BIT_HALT_BYTE   5
`define BIT_EDGE_SEL    4
`define BIT_GATE_ON     3
`define BIT_LEN_CLR     2
`define BIT_TBL_CLR     1

// ----------------------------------------------------------------
// Stuck register fields and reset values
// ----------------------------------------------------------------
`define STUCK_SDA_LSB   0
`define STUCK_SCL_LSB   4
`define CTRL_RST        8'h00
`define CHAN_ON_RST     3'h0

// ----------------------------------------------------------------
// Bus encodings
// ----------------------------------------------------------------
`define HTRANS_NONSEQ_BIT 1
`define CH_NONE         2'h3

`endif

//--- logic/trig_edge.v
// Trigger pin synchroniser with selectable edge and gate
module trig_edge (
  hclk,
  hresetn,
  trig_pin,
  edge_sel,
  gate_on,
  trig_tick
);
  input  wire hclk;
  input  wire hresetn;
  input  wire trig_pin;
  input  wire edge_sel;
  input  wire gate_on;
  output reg  trig_tick;

  // ----------------------------------------------------------------
  // Two-stage sync, then edge history
  // ----------------------------------------------------------------
  reg meta_r;
  reg sync_r;
  reg prev_r;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_r    <= 1'b0;
      sync_r    <= 1'b0;
      prev_r    <= 1'b0;
      trig_tick <= 1'b0;
    end else begin
      meta_r    <= trig_pin;
      sync_r    <= meta_r;
      prev_r    <= sync_r;
      // Falling when select is 1, rising when 0
      trig_tick <= gate_on & (edge_sel ? (prev_r & ~sync_r) : (~prev_r & sync_r));
    end
  end
endmodule

//--- logic/bus_watch.v
// Serial line monitor: sync, STOP detect, stuck-line levels
module bus_watch (
  hclk,
  hresetn,
  scl_pin,
  sda_pin,
  stop_seen,
  bus_free,
  sda_low,
  scl_low
);
  input  wire hclk;
  input  wire hresetn;
  input  wire scl_pin;
  input  wire sda_pin;
  output reg  stop_seen;
  output wire bus_free;
  output wire sda_low;
  output wire scl_low;

  // ----------------------------------------------------------------
  // Two-stage sync of both lines
  // ----------------------------------------------------------------
  reg scl_m_r;
  reg scl_s_r;
  reg sda_m_r;
  reg sda_s_r;
  reg sda_p_r;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scl_m_r   <= 1'b1;
      scl_s_r   <= 1'b1;
      sda_m_r   <= 1'b1;
      sda_s_r   <= 1'b1;
      sda_p_r   <= 1'b1;
      stop_seen <= 1'b0;
    end else begin
      scl_m_r   <= scl_pin;
      scl_s_r   <= scl_m_r;
      sda_m_r   <= sda_pin;
      sda_s_r   <= sda_m_r;
      sda_p_r   <= sda_s_r;
      // STOP: data rises while clock high
      stop_seen <= scl_s_r & sda_s_r & ~sda_p_r;
    end
  end

  assign bus_free = scl_s_r & sda_s_r;
  assign sda_low  = ~sda_s_r;
  assign scl_low  = ~scl_s_r;
endmodule

//--- logic/i2c_channel_control_reg.v
// Per-channel control registers of the serial master, AHB-Lite slave
//
// Function
// - Begin bit clears when halt-after-byte is set and current byte is done.
// - No START is requested while begin bit is 0.
// - Halt-after-byte (bit 5) sends STOP right after the current byte.
// - A read under halt-after-byte gets NACK before the STOP.
// - After halt-after-byte, flush queued transactions and return to idle.
// - Halt-after-byte clears on STOP seen; writing 0 does nothing.
// - Edge select bit 4: 1 falling, 0 rising trigger edges.
// - Edge select and trigger gate are frozen while the channel is active.
// - Gate on (bit 3): each trigger after begin, while the channel is not active and no halt is pending, launches START and sequence.
// - Gate off: trigger input ignored.
// - Bit 2 write-1 clears length-list pointer; reads 0.
// - Bit 1 clears table pointers, loads data pointer; reads 0.
// - Trigger coinciding with begin being set is ignored.
// - Halt bits written while begin is 0 are ignored.
// - Halt-after-byte wins over halt-after-sequence.
// - Begin checks bus; if free, begin sets (with START only when gate is off), else stuck error event.
// - Halt-after-sequence (bit 7) stops after sequence, clears on STOP.
// - With gate off, begin clears at sequence end with count 1 or loop end above 1.
`include "i2c_ctl_defs.vh"

module i2c_channel_control_reg #(
  parameter FC_W = 8
) (
  hclk,
  hresetn,
  hsel,
  haddr,
  htrans,
  hwrite,
  hsize,
  hwdata,
  hready,
  hreadyout,
  hresp,
  hrdata,
  trig_pin,
  scl_pin,
  sda_pin,
  chan_active,
  read_busy,
  byte_done,
  seq_done,
  loop_done,
  loop_frame_count,
  start_req,
  stop_after_byte,
  nack_before_stop,
  stop_after_seq,
  flush_queue,
  length_pointer_clear,
  table_pointer_clear,
  data_ptr_load,
  bus_err_event,
  sda_stuck_error,
  scl_stuck_error
);
  input  wire                      hclk;
  input  wire                      hresetn;
  input  wire                      hsel;
  input  wire [31:0]               haddr;
  input  wire [1:0]                htrans;
  input  wire                      hwrite;
  input  wire [2:0]                hsize;
  input  wire [31:0]               hwdata;
  input  wire                      hready;
  output wire                      hreadyout;
  output wire                      hresp;
  output reg  [31:0]               hrdata;
  input  wire [`CH_NUM-1:0]        trig_pin;
  input  wire [`CH_NUM-1:0]        scl_pin;
  input  wire [`CH_NUM-1:0]        sda_pin;
  input  wire [`CH_NUM-1:0]        chan_active;
  input  wire [`CH_NUM-1:0]        read_busy;
  input  wire [`CH_NUM-1:0]        byte_done;
  input  wire [`CH_NUM-1:0]        seq_done;
  input  wire [`CH_NUM-1:0]        loop_done;
  input  wire [`CH_NUM*FC_W-1:0]   loop_frame_count;
  output reg  [`CH_NUM-1:0]        start_req;
  output wire [`CH_NUM-1:0]        stop_after_byte;
  output wire [`CH_NUM-1:0]        nack_before_stop;
  output wire [`CH_NUM-1:0]        stop_after_seq;
  output wire [`CH_NUM-1:0]        flush_queue;
  output reg  [`CH_NUM-1:0]        length_pointer_clear;
  output reg  [`CH_NUM-1:0]        table_pointer_clear;
  output reg  [`CH_NUM-1:0]        data_ptr_load;
  output reg  [`CH_NUM-1:0]        bus_err_event;
  output reg  [`CH_NUM-1:0]        sda_stuck_error;
  output reg  [`CH_NUM-1:0]        scl_stuck_error;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function [1:0] chan_decode;
    input [7:0] a;
    begin
      case (a)
        `OFS_CH0_CTRL: chan_decode = 2'h0;
        `OFS_CH1_CTRL: chan_decode = 2'h1;
        `OFS_CH2_CTRL: chan_decode = 2'h2;
        default:       chan_decode = `CH_NONE;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // Sticky flag update: set wins over clear
  // ----------------------------------------------------------------
  function flag_next;
    input set;
    input hold;
    input clr;
    begin
      flag_next = set | (hold & ~clr);
    end
  endfunction

  // ----------------------------------------------------------------
  // Per-channel state
  // ----------------------------------------------------------------
  reg  [`CH_NUM-1:0] halt_seq_r;
  reg  [`CH_NUM-1:0] begin_r;
  reg  [`CH_NUM-1:0] halt_byte_r;
  reg  [`CH_NUM-1:0] edge_sel_r;
  reg  [`CH_NUM-1:0] gate_on_r;
  reg  [`CH_NUM-1:0] armed_r;
  reg  [`CH_NUM-1:0] channel_on_r;
  wire [`CH_NUM-1:0] trig_tick;
  wire [`CH_NUM-1:0] stop_seen;
  wire [`CH_NUM-1:0] bus_free;
  wire [`CH_NUM-1:0] sda_low;
  wire [`CH_NUM-1:0] scl_low;

  // ----------------------------------------------------------------
  // AHB-Lite slave: address phase capture
  // ----------------------------------------------------------------
  reg        wr_pend_r;
  reg        rd_pend_r;
  reg        rd_wait_r;
  reg  [7:0] addr_r;
  wire       addr_ok;
  wire [1:0] wr_ch;
  wire       wr_on;
  wire       wr_stuck;
  wire [7:0] wbyte;

  assign addr_ok   = hsel & htrans[`HTRANS_NONSEQ_BIT] & hready;
  assign hreadyout = ~rd_wait_r;
  assign hresp     = 1'b0;
  assign wbyte     = hwdata[7:0];
  assign wr_ch     = wr_pend_r ? chan_decode(addr_r) : `CH_NONE;
  assign wr_on     = wr_pend_r & (addr_r == `OFS_CHAN_ON);
  assign wr_stuck  = wr_pend_r & (addr_r == `OFS_STUCK);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      rd_wait_r <= 1'b0;
      addr_r    <= 8'h00;
    end else begin
      if (addr_ok) begin
        addr_r <= haddr[7:0];
      end
      wr_pend_r <= addr_ok & hwrite;
      rd_pend_r <= addr_ok & ~hwrite;
      // One wait cycle so read data comes from a flop after any write lands
      rd_wait_r <= addr_ok & ~hwrite;
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  reg [7:0] rd_byte;
  reg [1:0] rd_ch;

  always @* begin
    rd_ch   = chan_decode(addr_r);
    rd_byte = 8'h00;
    if (rd_ch != `CH_NONE) begin
      // Pointer strobes and reserved bit read 0
      rd_byte = {halt_seq_r[rd_ch], begin_r[rd_ch], halt_byte_r[rd_ch],
                 edge_sel_r[rd_ch], gate_on_r[rd_ch], 3'h0};
    end else if (addr_r == `OFS_CHAN_ON) begin
      rd_byte = {5'h00, channel_on_r};
    end else if (addr_r == `OFS_STUCK) begin
      rd_byte = {1'b0, scl_stuck_error, 1'b0, sda_stuck_error};
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (rd_pend_r && rd_wait_r) begin
      hrdata <= {24'h000000, rd_byte};
    end
  end

  // ----------------------------------------------------------------
  // Channel enable register
  // ----------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      channel_on_r <= `CHAN_ON_RST;
    end else if (wr_on) begin
      channel_on_r <= wbyte[`CH_NUM-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Channel control logic
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < `CH_NUM; i = i + 1) begin : g_ch
      wire            wr;
      wire            try_begin;
      wire            set_begin;
      wire            clr_begin;
      wire            set_halt_byte;
      wire            set_halt_seq;
      wire            clr_sda;
      wire            clr_scl;
      wire [FC_W-1:0] fc;
      wire            fc_one;
      wire            fc_many;
      wire            count_mode;

      assign wr        = (wr_ch == i);
      assign fc        = loop_frame_count[i*FC_W +: FC_W];
      assign fc_one    = (fc == {{(FC_W-1){1'b0}}, 1'b1});
      assign fc_many   = (fc > {{(FC_W-1){1'b0}}, 1'b1});
      // Frame count only matters with the trigger gate off
      assign count_mode = ~gate_on_r[i];
      // Begin accepted only from idle with channel enabled
      assign try_begin = wr & wbyte[`BIT_BEGIN] & channel_on_r[i] & ~begin_r[i] & ~chan_active[i];
      assign set_begin = try_begin & bus_free[i];
      assign clr_begin = (halt_byte_r[i] & byte_done[i])
                       | (count_mode & seq_done[i] & fc_one)
                       | (count_mode & loop_done[i] & fc_many)
                       | (halt_seq_r[i] & seq_done[i] & (~fc_one | ~count_mode));
      // Halt requests need a running begin; a write of 0 leaves them
      assign set_halt_byte = wr & wbyte[`BIT_HALT_BYTE] & begin_r[i];
      assign set_halt_seq  = wr & wbyte[`BIT_HALT_SEQ] & begin_r[i];
      assign clr_sda       = wr_stuck & wbyte[`STUCK_SDA_LSB + i];
      assign clr_scl       = wr_stuck & wbyte[`STUCK_SCL_LSB + i];

      // ------------------------------------------------------------
      // Control flags
      // ------------------------------------------------------------
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          begin_r[i]     <= 1'b0;
          halt_byte_r[i] <= 1'b0;
          halt_seq_r[i]  <= 1'b0;
          edge_sel_r[i]  <= 1'b0;
          gate_on_r[i]   <= 1'b0;
          armed_r[i]     <= 1'b0;
        end else begin
          begin_r[i]     <= flag_next(set_begin, begin_r[i], clr_begin);
          halt_byte_r[i] <= flag_next(set_halt_byte, halt_byte_r[i], stop_seen[i]);
          halt_seq_r[i]  <= flag_next(set_halt_seq, halt_seq_r[i], stop_seen[i]);
          if (wr && !chan_active[i]) begin
            edge_sel_r[i] <= wbyte[`BIT_EDGE_SEL];
            gate_on_r[i]  <= wbyte[`BIT_GATE_ON];
          end
          // Armed one cycle after begin, so a coincident trigger is dropped
          armed_r[i] <= begin_r[i] & ~clr_begin;
        end
      end

      // ------------------------------------------------------------
      // Sequencer strobes
      // ------------------------------------------------------------
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          start_req[i]            <= 1'b0;
          length_pointer_clear[i] <= 1'b0;
          table_pointer_clear[i]  <= 1'b0;
          data_ptr_load[i]        <= 1'b0;
        end else begin
          if (gate_on_r[i]) begin
            start_req[i] <= armed_r[i] & begin_r[i] & trig_tick[i] & ~chan_active[i]
                          & ~halt_byte_r[i] & ~halt_seq_r[i];
          end else begin
            start_req[i] <= set_begin;
          end
          length_pointer_clear[i] <= wr & wbyte[`BIT_LEN_CLR];
          table_pointer_clear[i]  <= wr & wbyte[`BIT_TBL_CLR];
          data_ptr_load[i]        <= wr & wbyte[`BIT_TBL_CLR];
        end
      end

      // ------------------------------------------------------------
      // Bus check and stuck flags
      // ------------------------------------------------------------
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          bus_err_event[i]   <= 1'b0;
          sda_stuck_error[i] <= 1'b0;
          scl_stuck_error[i] <= 1'b0;
        end else begin
          bus_err_event[i]   <= try_begin & ~bus_free[i];
          // Stuck flags: set wins over a write-1 clear
          sda_stuck_error[i] <= flag_next(try_begin & sda_low[i], sda_stuck_error[i], clr_sda);
          scl_stuck_error[i] <= flag_next(try_begin & scl_low[i], scl_stuck_error[i], clr_scl);
        end
      end

      // ------------------------------------------------------------
      // Sequencer requests
      // ------------------------------------------------------------
      assign stop_after_byte[i]  = halt_byte_r[i];
      assign nack_before_stop[i] = halt_byte_r[i] & read_busy[i];
      assign stop_after_seq[i]   = halt_seq_r[i] & ~halt_byte_r[i];
      assign flush_queue[i]      = halt_byte_r[i] | halt_seq_r[i];

      trig_edge u_trig (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .trig_pin  (trig_pin[i]),
        .edge_sel  (edge_sel_r[i]),
        .gate_on   (gate_on_r[i]),
        .trig_tick (trig_tick[i])
      );

      bus_watch u_watch (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .scl_pin   (scl_pin[i]),
        .sda_pin   (sda_pin[i]),
        .stop_seen (stop_seen[i]),
        .bus_free  (bus_free[i]),
        .sda_low   (sda_low[i]),
        .scl_low   (scl_low[i])
      );
    end
  endgenerate
endmodule

//--- verif/i2c_ctl_chk_sva.sv
// Port checker for the channel control block
module i2c_ctl_chk (
  input wire        hclk,
  input wire        hresetn,
  input wire [31:0] hwdata,
  input wire        hreadyout,
  input wire        hresp,
  input wire [2:0]  scl_pin,
  input wire [2:0]  sda_pin,
  input wire [2:0]  chan_active,
  input wire [2:0]  read_busy,
  input wire [2:0]  start_req,
  input wire [2:0]  stop_after_byte,
  input wire [2:0]  nack_before_stop,
  input wire [2:0]  stop_after_seq,
  input wire [2:0]  flush_queue,
  input wire [2:0]  length_pointer_clear,
  input wire [2:0]  table_pointer_clear,
  input wire [2:0]  data_ptr_load,
  input wire [2:0]  bus_err_event,
  input wire [2:0]  sda_stuck_error,
  input wire [2:0]  scl_stuck_error
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ----------------------------------------
  // Cycles since a raw STOP on channel 0
  // ----------------------------------------
  logic [3:0] age_r;
  logic       sda_prev_r;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      age_r      <= 4'hf;
      sda_prev_r <= 1'b1;
    end else begin
      sda_prev_r <= sda_pin[0];
      if (sda_pin[0] && !sda_prev_r && scl_pin[0])
        age_r <= 4'h0;
      else if (age_r != 4'hf)
        age_r <= age_r + 4'h1;
    end
  end
  property p_nack; nack_before_stop == (stop_after_byte & read_busy); endproperty
  a_nack: assert property (p_nack) else $error("nack not tied to halt and read");
  property p_prio; stop_after_byte[0] |-> !stop_after_seq[0]; endproperty
  a_prio: assert property (p_prio) else $error("sequence halt beat byte halt");
  property p_flush; flush_queue == (stop_after_byte | stop_after_seq); endproperty
  a_flush: assert property (p_flush) else $error("flush wrong");
  property p_halt_set; $rose(stop_after_byte[0]) |-> $past(hwdata[5]); endproperty
  a_halt_set: assert property (p_halt_set) else $error("halt set without write");
  property p_halt_clr; $fell(stop_after_byte[0]) |-> age_r < 4'h8; endproperty
  a_halt_clr: assert property (p_halt_clr) else $error("halt cleared without stop");
  property p_start_one; start_req[0] |=> !start_req[0]; endproperty
  a_start_one: assert property (p_start_one) else $error("start longer than a cycle");
  property p_start_idle; start_req[0] |-> !$past(chan_active[0]); endproperty
  a_start_idle: assert property (p_start_idle) else $error("start while active");
  property p_len_clr; length_pointer_clear[0] |-> $past(hwdata[2]) ##1 !length_pointer_clear[0]; endproperty
  a_len_clr: assert property (p_len_clr) else $error("length clear wrong");
  property p_tbl_clr; table_pointer_clear == data_ptr_load; endproperty
  a_tbl_clr: assert property (p_tbl_clr) else $error("table clear without load");
  property p_err;
    ((bus_err_event & ~(sda_stuck_error | scl_stuck_error)) | (bus_err_event & start_req)) == 3'h0;
  endproperty
  a_err: assert property (p_err) else $error("bus error without stuck flag");
  property p_rd_wait; !hreadyout |=> hreadyout && !hresp; endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("wait state too long");
endmodule

bind i2c_channel_control_reg i2c_ctl_chk u_chk (.hclk, .hresetn, .hwdata, .hreadyout, .hresp, .scl_pin,
  .sda_pin, .chan_active, .read_busy, .start_req, .stop_after_byte, .nack_before_stop, .stop_after_seq,
  .flush_queue, .length_pointer_clear, .table_pointer_clear, .data_ptr_load, .bus_err_event,
  .sda_stuck_error, .scl_stuck_error);

//--- verif/serial_far_end.sv
// Serial far end: pulled-up lines, STOP maker, stuck data line
module serial_far_end (
  input  wire logic       hclk,
  input  wire logic [2:0] stop_go,
  input  wire logic [2:0] sda_hold,
  output logic      [2:0] scl_pin,
  output logic      [2:0] sda_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_r [3];
  initial for (int i = 0; i < 3; i++) cnt_r[i] = 4'h0;
  always @(posedge hclk)
    for (int i = 0; i < 3; i++)
      cnt_r[i] <= stop_go[i] ? 4'h8 : ((cnt_r[i] != 4'h0) ? cnt_r[i] - 4'h1 : 4'h0);
  always_comb begin
    scl_pin = 3'h7;
    for (int i = 0; i < 3; i++)
      sda_pin[i] = ~(sda_hold[i] | (cnt_r[i] != 4'h0));
  end
endmodule

//--- verif/i2c_channel_control_reg_tb.sv
// Self-checking bench for the channel control block
module i2c_channel_control_reg_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  wire         hready = hreadyout;
  logic [2:0]  trig_pin, scl_pin, sda_pin, chan_active, read_busy, byte_done, seq_done, loop_done;
  logic [2:0]  start_req, stop_after_byte, nack_before_stop, stop_after_seq, flush_queue;
  logic [2:0]  length_pointer_clear, table_pointer_clear, data_ptr_load, bus_err_event;
  logic [2:0]  sda_stuck_error, scl_stuck_error, stop_go, sda_hold;
  logic [23:0] loop_frame_count;
  logic [7:0]  ca;
  logic [7:0]  ra [6] = '{8'hc0, 8'hd0, 8'he0, 8'hf0, 8'hf4, 8'h44};
  int          err_total, total_checks, n_lp, n_tp, n_be;
  int          n_st [3];

  i2c_channel_control_reg DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready, .hreadyout, .hresp, .hrdata, .trig_pin, .scl_pin, .sda_pin, .chan_active, .read_busy,
    .byte_done, .seq_done, .loop_done, .loop_frame_count, .start_req, .stop_after_byte,
    .nack_before_stop, .stop_after_seq, .flush_queue, .length_pointer_clear, .table_pointer_clear,
    .data_ptr_load, .bus_err_event, .sda_stuck_error, .scl_stuck_error);
  serial_far_end far_end (.hclk, .stop_go, .sda_hold, .scl_pin, .sda_pin);

  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    for (int i = 0; i < 3; i++) n_st[i] += (start_req[i] === 1'b1);
    n_lp += (length_pointer_clear[0] === 1'b1);
    n_tp += (table_pointer_clear[0] === 1'b1);
    n_be += (bus_err_event[1] === 1'b1);
  end
  // ----------------------------------------
  // Bus and check tasks
  // ----------------------------------------
  task chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", n, exp, got);
    end
  endtask
  task xfer(input logic [7:0] a, input logic w, input logic [7:0] d, output logic [31:0] q);
    bit r;
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do begin @(negedge hclk); r = hreadyout; @(posedge hclk); end while (!r);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do begin @(negedge hclk); r = hreadyout; q = hrdata; @(posedge hclk); end while (!r);
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    xfer(a, 1'b1, d, q);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    xfer(a, 1'b0, 8'h00, q);
    chk($sformatf("reg %h", a), q, e);
  endtask
  task pulse(input int k, input int c);
    case (k)
      0: byte_done[c] <= 1'b1;
      1: seq_done[c] <= 1'b1;
      default: loop_done[c] <= 1'b1;
    endcase
    @(posedge hclk);
    {byte_done, seq_done, loop_done} <= 9'h000;
    repeat (2) @(posedge hclk);
  endtask
  task trig(input int c);
    trig_pin[c] <= ~trig_pin[c];
    repeat (12) @(posedge hclk);
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #100000;
    err_total++;
    summarize;
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    {trig_pin, chan_active, read_busy, byte_done, seq_done, loop_done, stop_go, sda_hold} = '0;
    loop_frame_count = 24'h0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    foreach (ra[i]) rd(ra[i], 32'h0);
    wr(8'hc0, 8'h40);
    rd(8'hc0, 32'h0);
    wr(8'hf0, 8'h07);
    rd(8'hf0, 32'h7);
    for (ca = 8'hc0; ca < 8'hf0; ca += 8'h10) begin
      wr(ca, 8'h40);
      rd(ca, 32'h40);
      chk("starts", n_st[ca[5:4]], 1);
    end
    wr(8'hc0, 8'h46);
    rd(8'hc0, 32'h40);
    chk("len clears", n_lp, 1);
    chk("tbl clears", n_tp, 1);
    read_busy <= 3'h1;
    wr(8'hc0, 8'he0);
    @(negedge hclk);
    chk("halt outs", {stop_after_byte[0], nack_before_stop[0], stop_after_seq[0], flush_queue[0]}, 4'hd);
    @(posedge hclk);
    wr(8'hc0, 8'h40);
    rd(8'hc0, 32'he0);
    pulse(0, 0);
    rd(8'hc0, 32'ha0);
    stop_go <= 3'h1;
    @(posedge hclk);
    stop_go <= 3'h0;
    repeat (16) @(posedge hclk);
    rd(8'hc0, 32'h0);
    read_busy <= 3'h0;
    wr(8'hc0, 8'ha0);
    rd(8'hc0, 32'h0);
    loop_frame_count <= 24'h030100;
    pulse(1, 1);
    rd(8'hd0, 32'h0);
    pulse(1, 2);
    rd(8'he0, 32'h40);
    pulse(2, 2);
    rd(8'he0, 32'h0);
    wr(8'hc0, 8'h08);
    wr(8'hc0, 8'h48);
    chk("gated start", n_st[0], 1);
    trig(0);
    chk("rise start", n_st[0], 2);
    trig(0);
    chk("fall ignored", n_st[0], 2);
    chan_active <= 3'h1;
    wr(8'hc0, 8'h58);
    chan_active <= 3'h0;
    rd(8'hc0, 32'h48);
    loop_frame_count <= 24'h030101;
    pulse(1, 0);
    rd(8'hc0, 32'h48);
    wr(8'he0, 8'h18);
    wr(8'he0, 8'h58);
    trig(2);
    chk("rise ignored", n_st[2], 1);
    trig(2);
    chk("fall start", n_st[2], 2);
    wr(8'he0, 8'h98);
    pulse(1, 2);
    rd(8'he0, 32'h98);
    sda_hold <= 3'h2;
    repeat (4) @(posedge hclk);
    wr(8'hd0, 8'h40);
    rd(8'hd0, 32'h0);
    rd(8'hf4, 32'h2);
    chk("bus errors", n_be, 1);
    chk("refused start", n_st[1], 1);
    sda_hold <= 3'h0;
    repeat (6) @(posedge hclk);
    wr(8'hf4, 8'h02);
    rd(8'hf4, 32'h0);
    wr(8'hd0, 8'h40);
    trig(1);
    trig(1);
    chk("gate off", n_st[1], 2);
    summarize;
  end
endmodule
